// File: design/cost_clock_output_startup_timer.sv
// Start-up delay timer, clock ready flag and glitch-free divided clock output.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - All timing runs from the main clock.
// - Reset pin is active low, resets device.
// - Start-up timer expires after 7500 main cycles.
// - Control register stays accessible during start-up.
// - Timer expiry sets the clock ready flag.
// - Output held low until first timer expiry.
// - First expiry starts output at the control rate, divide by four from reset.
// - Pin or soft reset leaves control unchanged.
// - Output keeps running during power-down.
// - Power-down exit restarts timer, not output.
// - Select codes give divide 1,2,3,4,8.
// - Select zero disables output, pin low.
// - No pulse shorter than new half-period.
// - Rate change holds output low for a 4-cycle gap.
module cost_clock_output_startup_timer #(
    parameter int STARTUP_CYCLES = cost_pkg::STARTUP_CYCLES_DEFAULT
) (
    input  wire logic                        clock,
    input  wire logic                        srst,
    input  wire logic                        reset_pin_n,
    input  wire logic                        soft_reset,
    input  wire logic                        power_down,
    input  wire logic                        ctrl_wr,
    input  wire logic [cost_pkg::CTRL_W-1:0] ctrl_wdata,
    output logic      [cost_pkg::CTRL_W-1:0] ctrl_rdata,
    output logic                             clock_ready_flag,
    output logic                             device_reset,
    output logic                             divided_clock_output
);
    import cost_pkg::*;

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(STARTUP_CYCLES - 1);

    cost_state_t      s_reg;
    cost_state_t      s_next;
    logic             div1_gate_reg;
    logic [SEL_W-1:0] req;
    logic [3:0]       per;
    logic [3:0]       half;
    logic [3:0]       cnt_n;

    assign req  = s_reg.started ? s_reg.ctrl : SEL_OFF;
    assign per  = cost_period(s_reg.active);
    assign half = per >> 1;

    always_comb begin
        s_next = s_reg;
        cnt_n  = 4'h0;
        // The pin passes two flops; the second one feeds the registered reset output.
        s_next.pin_meta = reset_pin_n;
        s_next.pin_sync = s_reg.pin_meta;
        s_next.dev_rst  = ~s_reg.pin_sync | soft_reset;
        // Writes are honoured at any time, also while the timer counts.
        if (ctrl_wr) begin
            s_next.ctrl = ctrl_wdata[SEL_LSB +: SEL_W];
        end
        if (power_down) begin
            s_next.timer = '0;
            s_next.ready = 1'b0;
        end else if (!s_reg.ready) begin
            if (s_reg.timer == TIMER_LAST) begin
                s_next.ready   = 1'b1;
                s_next.started = 1'b1;
            end else begin
                s_next.timer = s_reg.timer + 1'b1;
            end
        end
        case (s_reg.phase)
            st_run: begin
                // A change waits for the end of a whole period so no high pulse is cut short.
                if (req != s_reg.active && (per <= 4'h1 || s_reg.cnt == per - 4'h1)) begin
                    s_next.phase = st_gap;
                    s_next.gap   = GAP_CYCLES - 3'h1;
                    s_next.out   = 1'b0;
                    s_next.div1  = 1'b0;
                    s_next.cnt   = 4'h0;
                end else if (per > 4'h1) begin
                    cnt_n        = (s_reg.cnt == per - 4'h1) ? 4'h0 : s_reg.cnt + 4'h1;
                    s_next.cnt   = cnt_n;
                    s_next.out   = (cnt_n < half) || (per == 4'h3 && cnt_n == 4'h0);
                end else begin
                    s_next.out   = 1'b0;
                end
            end
            st_gap: begin
                if (s_reg.gap == 3'h0) begin
                    s_next.phase  = st_run;
                    s_next.active = req;
                    s_next.cnt    = 4'h0;
                    s_next.out    = cost_period(req) > 4'h1;
                    s_next.div1   = (req == SEL_DIV1);
                end else begin
                    s_next.gap = s_reg.gap - 3'h1;
                end
            end
            default: s_next.phase = st_run;
        endcase
        // Of the resets, only power-on reset touches the control register; writes also change it.
        if (srst) begin
            s_next         = '0;
            s_next.ctrl    = CTRL_RESET[SEL_LSB +: SEL_W];
            s_next.phase   = st_run;
            s_next.active  = SEL_OFF;
            s_next.dev_rst = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        s_reg <= s_next;
    end

    // The divide-by-one gate changes on the falling edge, so the passed clock is never sliced.
    always_ff @(negedge clock) begin
        div1_gate_reg <= srst ? 1'b0 : s_reg.div1;
    end

    assign divided_clock_output = (clock & div1_gate_reg) | s_reg.out;
    assign ctrl_rdata           = {{(CTRL_W-SEL_W){1'b0}}, s_reg.ctrl};
    assign clock_ready_flag     = s_reg.ready;
    assign device_reset         = s_reg.dev_rst;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // Start-up timer and ready flag.
    a_ready_at_count: assert property ($rose(s_reg.ready) |-> $past(s_reg.timer) == TIMER_LAST)
        else $error("ready flag rose at wrong count");

    a_timer_step: assert property ((!s_reg.ready && !power_down && s_reg.timer != TIMER_LAST)
        |=> s_reg.timer == $past(s_reg.timer) + 1'b1)
        else $error("start-up timer did not advance");

    a_ready_holds: assert property ((s_reg.ready && !power_down) |=> s_reg.ready)
        else $error("ready flag dropped without power-down");

    a_pd_clears_ready: assert property (power_down |=> !clock_ready_flag)
        else $error("ready flag set during power-down");

    a_pd_timer_clear: assert property (power_down |=> s_reg.timer == '0)
        else $error("timer not restarted by power-down");

    // Reset pin and soft reset paths and control register.
    a_pin_resets: assert property (!s_reg.pin_sync |=> device_reset)
        else $error("reset pin did not reset the device");

    a_soft_resets: assert property (soft_reset |=> device_reset)
        else $error("soft reset did not reset the device");

    a_reset_release: assert property ((s_reg.pin_sync && !soft_reset) |=> !device_reset)
        else $error("device reset stuck after release");

    a_write_lands: assert property (ctrl_wr
        |=> ctrl_rdata[SEL_W-1:0] == $past(ctrl_wdata[SEL_W-1:0]))
        else $error("control write not taken");

    a_ctrl_kept: assert property (!ctrl_wr |=> $stable(ctrl_rdata))
        else $error("control changed without a write");

    // Output gating.
    a_off_low: assert property ((s_reg.phase == st_run && s_reg.active == SEL_OFF) |-> !s_reg.out && !s_reg.div1)
        else $error("output active while disabled");

    a_reserved_low: assert property ((s_reg.phase == st_run && s_reg.active[2:1] == 2'h3)
        |-> !s_reg.out && !s_reg.div1)
        else $error("output active for a reserved code");

    a_gap_length: assert property ((s_reg.phase == st_gap && $past(s_reg.phase) == st_run)
        |-> (s_reg.phase == st_gap && !s_reg.out)[*4] ##1 s_reg.phase == st_run)
        else $error("gap not four low cycles");

    a_gap_gate_off: assert property (s_reg.phase == st_gap |-> !s_reg.div1 && !s_reg.out)
        else $error("output driven during the gap");

    a_gap_new_rate: assert property ((s_reg.phase == st_run && $past(s_reg.phase) == st_gap)
        |-> s_reg.active == $past(req))
        else $error("new rate differs from request");

    a_hold_before_start: assert property (!s_reg.started |-> !s_reg.out && !s_reg.div1)
        else $error("output toggled before first expiry");

    a_started_stays: assert property (s_reg.started |=> s_reg.started)
        else $error("output stopped after first expiry");

    a_run_no_regate: assert property ((s_reg.phase == st_run && req == s_reg.active) |=> s_reg.phase == st_run)
        else $error("output re-gated without rate change");

    a_pd_keeps_out: assert property ((power_down && s_reg.phase == st_run && s_reg.active == SEL_DIV4
        && $rose(s_reg.out)) |-> s_reg.out[*2])
        else $error("output disturbed by power-down");

    // Waveform of each rate.
    a_div1_pass: assert property ((s_reg.phase == st_run && s_reg.active == SEL_DIV1)
        |-> s_reg.div1 && !s_reg.out)
        else $error("divide by one not passed through");

    a_div2_wave: assert property ((s_reg.phase == st_run && s_reg.active == SEL_DIV2 && $rose(s_reg.out))
        |-> ##1 !s_reg.out)
        else $error("divide by two waveform wrong");

    a_div3_wave: assert property ((s_reg.phase == st_run && s_reg.active == SEL_DIV3 && $rose(s_reg.out))
        |-> ##1 !s_reg.out[*2])
        else $error("divide by three waveform wrong");

    a_div4_high: assert property ((s_reg.phase == st_run && s_reg.active == SEL_DIV4 && $rose(s_reg.out))
        |-> s_reg.out[*2] ##1 !s_reg.out[*2])
        else $error("divide by four half-period wrong");

    a_div8_wave: assert property ((s_reg.phase == st_run && s_reg.active == SEL_DIV8 && $rose(s_reg.out))
        |-> s_reg.out[*4] ##1 !s_reg.out[*4])
        else $error("divide by eight waveform wrong");

    a_first_rate: assert property ((s_reg.started && !$past(s_reg.started) && s_reg.ctrl == SEL_DIV4)
        |-> ##[1:8] s_reg.active == SEL_DIV4)
        else $error("default rate not started");

    // Main scenarios that the bench is expected to reach.
    c_ready: cover property ($rose(clock_ready_flag));
    c_gap: cover property (s_reg.phase == st_gap);
    c_div1: cover property (div1_gate_reg);
    c_div8: cover property (s_reg.active == SEL_DIV8 && $rose(s_reg.out));
    c_power_down: cover property (power_down && s_reg.started);
endmodule
`default_nettype wire

// File: include/cost_pkg.sv
// Constants, types and helpers for the clock start-up and clock-output block.
package cost_pkg;
    localparam int          MAIN_CLOCK_HZ          = 40000000;
    localparam int          STARTUP_TIME_US        = 300;
    localparam int          STARTUP_CYCLES_DEFAULT = 7500;
    localparam int          TIMER_W                = 13;
    localparam int          CTRL_W                 = 8;
    localparam int          SEL_W                  = 3;
    localparam int          SEL_LSB                = 0;
    localparam logic [7:0]  CTRL_RESET             = 8'h04;
    localparam logic [2:0]  SEL_OFF                = 3'h0;
    localparam logic [2:0]  SEL_DIV1               = 3'h1;
    localparam logic [2:0]  SEL_DIV2               = 3'h2;
    localparam logic [2:0]  SEL_DIV3               = 3'h3;
    localparam logic [2:0]  SEL_DIV4               = 3'h4;
    localparam logic [2:0]  SEL_DIV8               = 3'h5;
    localparam logic [2:0]  GAP_CYCLES             = 3'h4;

    typedef enum logic {st_run, st_gap} cost_phase_t;

    typedef struct packed {
        logic                pin_meta;
        logic                pin_sync;
        logic                dev_rst;
        logic [SEL_W-1:0]    ctrl;
        logic [TIMER_W-1:0]  timer;
        logic                ready;
        logic                started;
        cost_phase_t         phase;
        logic [SEL_W-1:0]    active;
        logic [3:0]          cnt;
        logic [2:0]          gap;
        logic                out;
        logic                div1;
    } cost_state_t;

    // Output period in main-clock cycles; zero means the output is held low.
    function automatic logic [3:0] cost_period(input logic [2:0] sel);
        case (sel)
            SEL_DIV1: cost_period = 4'h1;
            SEL_DIV2: cost_period = 4'h2;
            SEL_DIV3: cost_period = 4'h3;
            SEL_DIV4: cost_period = 4'h4;
            SEL_DIV8: cost_period = 4'h8;
            default:  cost_period = 4'h0;
        endcase
    endfunction
endpackage

// File: tb/cost_clock_output_startup_timer_bench.sv
// Self-checking bench for the start-up timer and divided clock output.
`timescale 1ns/1ps
`default_nettype none
module cost_clock_output_startup_timer_bench;
    import cost_pkg::*;
    localparam int SC = 16;
    logic       clock, srst, reset_pin_n, soft_reset, power_down, ctrl_wr, rdy, dres, dco;
    logic [7:0] ctrl_wdata, ctrl_rdata, sel;
    int         bad_count = 0, n_tests = 0, n;
    realtime    t [0:3];
    cost_clock_output_startup_timer #(.STARTUP_CYCLES(SC)) i_cost_clock_output_startup_timer (
        .clock(clock), .srst(srst), .reset_pin_n(reset_pin_n), .soft_reset(soft_reset),
        .power_down(power_down), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
        .clock_ready_flag(rdy), .device_reset(dres), .divided_clock_output(dco));
    cost_host_model i_cost_host_model (
        .clock(clock), .clock_ready_flag(rdy), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", w, e, g);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic ready_in(input int e);
        i_cost_host_model.wait_ready(n);
        check("ready delay", e, n);
        if (n >= 100) finish_test();
    endtask
    // Edge times in tenths of a ns keep the undivided half period whole.
    task automatic measure(input logic [2:0] s, input bit gap);
        int p, k, st;
        logic prev;
        p = (s == 3'h5) ? 8 : s;
        st = 1;
        t[0] = $realtime;
        #1;
        prev = dco;
        for (k = 0; k < 800 && st < 4; k++) begin
            #2.5;
            if (dco !== prev && (st > 1 || dco === 1'b1)) begin
                t[st] = $realtime;
                st++;
            end
            prev = dco;
        end
        if (st < 4) begin
            bad_count++;
            finish_test();
        end
        if (gap) check("gap", 1, t[1] - t[0] >= 50 && t[1] - t[0] <= 250);
        check("high", (p == 1) ? 125 : 250 * (p / 2), int'((t[2] - t[1]) * 10));
        check("low", (p == 1) ? 125 : 250 * (p - p / 2), int'((t[3] - t[2]) * 10));
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        reset_pin_n = 1'b1;
        soft_reset = 1'b0;
        power_down = 1'b0;
        void'($urandom(88));
        repeat (6) @(negedge clock);
        check("ctrl reset", CTRL_RESET, ctrl_rdata);
        srst = 1'b0;
        ready_in(SC);
        check("early out", 0, dco);
        measure(SEL_DIV4, 1'b1);
        @(negedge clock);
        reset_pin_n = 1'b0;
        soft_reset = 1'($urandom_range(1, 0));
        repeat (5) @(negedge clock);
        check("dev reset", 1, dres);
        measure(SEL_DIV4, 1'b0);
        check("ctrl kept", CTRL_RESET, ctrl_rdata);
        @(negedge clock);
        reset_pin_n = 1'b1;
        soft_reset = 1'b0;
        power_down = 1'b1;
        repeat (2) @(negedge clock);
        check("ready clr", 0, rdy);
        measure(SEL_DIV4, 1'b0);
        check("dev reset off", 0, dres);
        @(negedge clock);
        power_down = 1'b0;
        i_cost_host_model.write_ctrl(8'hFD);
        check("ctrl start", 8'h05, ctrl_rdata);
        ready_in(SC - 2);
        measure(SEL_DIV8, 1'b0);
        for (int i = 0; i < 8; i++) begin
            sel = (i < 5) ? 8'(i + 1) : 8'($urandom_range(5, 1));
            i_cost_host_model.write_ctrl(8'h00);
            repeat (12) @(negedge clock);
            check("off", 0, dco);
            i_cost_host_model.write_ctrl(sel);
            check("ctrl", sel, ctrl_rdata);
            measure(sel[2:0], 1'b1);
        end
        finish_test();
    end
endmodule
`default_nettype wire

// File: tb/cost_host_model.sv
// Host model that writes the output control register and polls the ready flag.
`timescale 1ns/1ps
`default_nettype none
module cost_host_model (
    input  wire logic       clock,
    input  wire logic       clock_ready_flag,
    output logic            ctrl_wr,
    output logic      [7:0] ctrl_wdata
);
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
    end
    // Reserved codes become off here; the device also holds the output low for them.
    task automatic write_ctrl(input logic [7:0] d);
        @(negedge clock);
        ctrl_wr = 1'b1;
        ctrl_wdata = (d[2:1] == 2'h3) ? {d[7:3], 3'h0} : d;
        @(negedge clock);
        ctrl_wr = 1'b0;
        ctrl_wdata = ~ctrl_wdata;
    endtask
    task automatic wait_ready(output int n);
        for (n = 0; n < 100 && clock_ready_flag !== 1'b1; n++) @(negedge clock);
    endtask
endmodule
`default_nettype wire
